// file: pwg_top.sv
// Function
// - pin carries pwm with ten-bit duty
// - zero control write forces output latch low
// - period is (limit+1) x4 x prescale
// - timer clears after matching period limit
// - boundary sets pin unless duty zero
// - boundary copies duty write into shadow
// - duty is write reg plus control bits5:4
// - duty changes wait for period end
// - shadow readable, writes ignored in pwm
// - shadow plus two-bit latch double-buffer
// - pin clears when duty matches extended timer
// - timer base is instruction cycle, four clocks
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pwg_regs.svh"
module pwg_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output pwg_pkg::pwg_resp_t s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output pwg_pkg::pwg_resp_t s_axi_rresp,
  // pulse output pin
  output logic pulse_pin_out,
  output logic pulse_pin_oe_n
);
  import pwg_pkg::*;

  // reset synchroniser
  logic rst_meta_q; // first stage, read only by the second
  logic rst_n_q; // released reset used everywhere

  // software registers
  logic [7:0] capture_control_reg; // mode and two low duty bits
  logic [7:0] period_limit_reg; // timer top value
  logic [7:0] duty_write_reg; // eight high duty bits
  logic [2:0] tmr_ctrl_q; // timer on and prescale
  logic port_direction_reg; // 1 = pin not driven

  // modulator state
  logic [7:0] period_timer_count; // period timer
  logic [7:0] duty_shadow_reg; // buffered high duty bits
  logic [1:0] duty_lo_q; // hidden buffered low duty bits
  logic out_latch_q; // modulator output latch
  logic pwm_mode; // control selects pwm
  logic boundary; // period ends this cycle
  logic [9:0] next_duty; // duty taken at the boundary
  logic duty_match; // buffered duty meets extended timer
  logic pin_d; // pin level for the next clock

  // write channel
  pwg_wr_st_t wr_st_q; // collect or respond
  logic aw_have_q; // address captured
  logic w_have_q; // data captured
  logic [ADDR_W-1:0] awaddr_q; // captured address
  logic [7:0] wdata_q; // captured low byte
  logic wstrb0_q; // low lane enabled
  logic wr_fire; // both halves present
  logic wr_hit; // address decodes

  // read channel
  logic [7:0] rd_byte; // decoded read value
  logic rd_hit; // read address decodes

  // time base link
  pwg_tick_if tk ();

  // two-stage reset release
  // assertion is immediate, release waits two edges so no flop
  // sees the reset lift close to its own clock edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // prescaler and quarter phase
  pwg_prescaler u_pre (
    .clk(clk),
    .rst_n(rst_n_q),
    .tk(tk.src)
  );

  assign tk.run = tmr_ctrl_q[`PWG_TCTRL_ON_BIT];
  assign tk.pre_sel = tmr_ctrl_q[`PWG_TCTRL_PRE_HI:`PWG_TCTRL_PRE_LO];

  // mode decode
  // both mode bits set select the modulator
  assign pwm_mode =
    (capture_control_reg[`PWG_CTRL_MODE_HI:`PWG_CTRL_MODE_LO] == `PWG_MODE_PWM);

  // period ends when the timer sits on the limit and advances
  assign boundary = tk.tick && (period_timer_count == period_limit_reg);

  // ten-bit duty assembled from write reg and control bits
  assign next_duty = {duty_write_reg,
    capture_control_reg[`PWG_CTRL_DLO_HI:`PWG_CTRL_DLO_LO]};

  // buffered duty against timer extended by two low bits
  assign duty_match =
    ({duty_shadow_reg, duty_lo_q} == {period_timer_count, tk.frac});

  // write handshake: address and data in either order
  assign wr_fire = (wr_st_q == PWG_WR_COLLECT) && aw_have_q && w_have_q;

  // write address decode
  always_comb begin
    case (awaddr_q)
      `PWG_CTRL_OFS: wr_hit = 1'b1;
      `PWG_PERIOD_OFS: wr_hit = 1'b1;
      `PWG_DUTY_WR_OFS: wr_hit = 1'b1;
      `PWG_DUTY_SH_OFS: wr_hit = 1'b1;
      `PWG_TIMER_OFS: wr_hit = 1'b1;
      `PWG_TCTRL_OFS: wr_hit = 1'b1;
      `PWG_DIR_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write address channel
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      // address taken: refuse more until the response is accepted
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // response accepted: reopen the address channel
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (!aw_have_q) begin
      // idle: offer ready
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      // data taken: only the low byte is ever used
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // response accepted: reopen the data channel
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (!w_have_q) begin
      // idle: offer ready
      s_axi_wready <= 1'b1;
    end
  end

  // write response, two cycles after both halves are taken
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_st_q <= PWG_WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PWG_RESP_OKAY;
    end else begin
      case (wr_st_q)
        PWG_WR_COLLECT: begin
          // both halves in hand: answer with the decode result
          if (wr_fire) begin
            wr_st_q <= PWG_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PWG_RESP_OKAY : PWG_RESP_SLVERR;
          end
        end
        PWG_WR_RESP: begin
          // answer stands until the master takes it
          if (s_axi_bready) begin
            wr_st_q <= PWG_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_st_q <= PWG_WR_COLLECT;
      endcase
    end
  end

  // plain software registers
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      capture_control_reg <= `PWG_CTRL_RST;
      period_limit_reg <= `PWG_PERIOD_RST;
      duty_write_reg <= `PWG_DUTY_RST;
      tmr_ctrl_q <= `PWG_TCTRL_RST;
      port_direction_reg <= `PWG_DIR_RST;
    end else if (wr_fire && wstrb0_q) begin
      // a write with the low lane off changes nothing
      case (awaddr_q)
        `PWG_CTRL_OFS: capture_control_reg <= wdata_q;
        `PWG_PERIOD_OFS: period_limit_reg <= wdata_q;
        // taken any time, used only at the next boundary
        `PWG_DUTY_WR_OFS: duty_write_reg <= wdata_q;
        `PWG_TCTRL_OFS: tmr_ctrl_q <= wdata_q[2:0];
        `PWG_DIR_OFS: port_direction_reg <= wdata_q[0];
        default: ;
      endcase
    end
  end

  // period timer: count on tick, clear after matching the limit
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      period_timer_count <= 8'h00;
    end else if (boundary) begin
      // limit reached on a tick: start a new period
      period_timer_count <= 8'h00;
    end else if (tk.tick) begin
      // one step per prescaled instruction cycle
      period_timer_count <= period_timer_count + 8'h01;
    end
  end

  // duty double buffer loaded at the period boundary
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      duty_shadow_reg <= 8'h00;
      duty_lo_q <= 2'h0;
    end else if (boundary) begin
      // both halves move together so a period never sees a mix
      duty_shadow_reg <= next_duty[9:2];
      duty_lo_q <= next_duty[1:0];
    end else if (wr_fire && wstrb0_q && !pwm_mode
                 && (awaddr_q == `PWG_DUTY_SH_OFS)) begin
      // outside pwm mode bus writes reach the shadow between boundary loads
      duty_shadow_reg <= wdata_q;
    end
  end

  // output latch: set at boundary, clear on duty match
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_latch_q <= 1'b0;
    end else if (wr_fire && wstrb0_q && (awaddr_q == `PWG_CTRL_OFS)
                 && (wdata_q == 8'h00)) begin
      out_latch_q <= 1'b0;
    end else if (!pwm_mode) begin
      // any other mode keeps the latch parked low
      out_latch_q <= 1'b0;
    end else if (boundary) begin
      // new period: set unless the new duty is zero
      out_latch_q <= (next_duty != 10'h000);
    end else if (duty_match) begin
      // duty reached: low for the rest of the period
      out_latch_q <= 1'b0;
    end
  end

  // the latch falls one clock after the match, so the pin takes the
  // match directly and the high time stays exactly duty steps long
  assign pin_d = out_latch_q && !duty_match;

  // pin driver: latch onto pin only while direction bit clear
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pulse_pin_out <= 1'b0;
      pulse_pin_oe_n <= 1'b1;
    end else begin
      pulse_pin_out <= pin_d;
      pulse_pin_oe_n <= port_direction_reg;
    end
  end

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `PWG_CTRL_OFS: rd_byte = capture_control_reg;
      `PWG_PERIOD_OFS: rd_byte = period_limit_reg;
      `PWG_DUTY_WR_OFS: rd_byte = duty_write_reg;
      `PWG_DUTY_SH_OFS: rd_byte = duty_shadow_reg;
      `PWG_TIMER_OFS: rd_byte = period_timer_count;
      `PWG_TCTRL_OFS: rd_byte = {5'h00, tmr_ctrl_q};
      `PWG_DIR_OFS: rd_byte = {7'h00, port_direction_reg};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PWG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      // address taken: data stand from the next edge
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? PWG_RESP_OKAY : PWG_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        // data accepted: reopen the address channel
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      // idle: offer ready
      s_axi_arready <= 1'b1;
    end
  end
endmodule : pwg_top
`default_nettype wire

// file: pwg_regs.svh
`ifndef PWG_REGS_SVH
`define PWG_REGS_SVH

// register byte offsets on the AXI4-Lite bus
`define PWG_CTRL_OFS 8'h00
`define PWG_PERIOD_OFS 8'h04
`define PWG_DUTY_WR_OFS 8'h08
`define PWG_DUTY_SH_OFS 8'h0C
`define PWG_TIMER_OFS 8'h10
`define PWG_TCTRL_OFS 8'h14
`define PWG_DIR_OFS 8'h18

// capture_control_reg fields
`define PWG_CTRL_DLO_HI 5
`define PWG_CTRL_DLO_LO 4
`define PWG_CTRL_MODE_HI 3
`define PWG_CTRL_MODE_LO 2
`define PWG_MODE_PWM 2'h3

// timer control fields
`define PWG_TCTRL_ON_BIT 2
`define PWG_TCTRL_PRE_HI 1
`define PWG_TCTRL_PRE_LO 0

// reset values
`define PWG_CTRL_RST 8'h00
`define PWG_PERIOD_RST 8'hFF
`define PWG_DUTY_RST 8'h00
`define PWG_TCTRL_RST 3'h0
`define PWG_DIR_RST 1'h1

// timing counts: oscillator periods per instruction cycle
`define PWG_OSC_PER_INSTR 4
`define PWG_QPHASE_LAST 2'h3

`endif

// file: pwg_pkg.sv
`default_nettype none
package pwg_pkg;
  // timer prescale selection
  typedef enum logic [1:0] {
    PWG_PRE_1 = 2'h0,
    PWG_PRE_4 = 2'h1,
    PWG_PRE_16 = 2'h2
  } pwg_pre_t;
  // AXI response codes
  typedef enum logic [1:0] {
    PWG_RESP_OKAY = 2'h0,
    PWG_RESP_SLVERR = 2'h2
  } pwg_resp_t;
  // write channel states
  typedef enum logic {
    PWG_WR_COLLECT,
    PWG_WR_RESP
  } pwg_wr_st_t;
endpackage : pwg_pkg
`default_nettype wire

// file: pwg_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
// time base link between the prescaler and the modulator
interface pwg_tick_if;
  logic run; // timer enabled
  logic [1:0] pre_sel; // prescale selection
  logic tick; // timer increment enable
  logic [1:0] frac; // two low compare bits
  modport src (input run, input pre_sel, output tick, output frac);
  modport snk (output run, output pre_sel, input tick, input frac);
endinterface : pwg_tick_if
`default_nettype wire

// file: pwg_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module pwg_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // time base link
  pwg_tick_if.src tk
);
  import pwg_pkg::*;

  logic [1:0] qphase_q; // quarter-cycle phase inside an instruction
  logic [3:0] precnt_q; // instruction cycles counted by the prescaler
  logic instr_end; // last quarter of an instruction
  logic pre_done; // prescaler wraps this instruction

  // quarter phase runs freely, four per instruction cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qphase_q <= 2'h0;
    end else begin
      qphase_q <= qphase_q + 2'h1;
    end
  end

  assign instr_end = (qphase_q == `PWG_QPHASE_LAST);

  // wrap point per prescale factor
  always_comb begin
    case (tk.pre_sel)
      PWG_PRE_1: pre_done = 1'b1;
      PWG_PRE_4: pre_done = (precnt_q[1:0] == 2'h3);
      default: pre_done = (precnt_q == 4'hF);
    endcase
  end

  // prescaler counts instruction cycles, held clear while stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      precnt_q <= 4'h0;
    end else if (!tk.run) begin
      precnt_q <= 4'h0;
    end else if (instr_end) begin
      precnt_q <= pre_done ? 4'h0 : precnt_q + 4'h1;
    end
  end

  // timer advances once per prescaled instruction cycle
  assign tk.tick = tk.run && instr_end && pre_done;

  // low compare bits: quarter phase or prescaler top bits
  always_comb begin
    case (tk.pre_sel)
      PWG_PRE_1: tk.frac = qphase_q;
      PWG_PRE_4: tk.frac = precnt_q[1:0];
      default: tk.frac = precnt_q[3:2];
    endcase
  end
endmodule : pwg_prescaler
`default_nettype wire

// file: pwg_load_model.sv
`timescale 1ns/10ps
`default_nettype none
// load on the pulse pin: measures high time and period in clocks
module pwg_load_model (
  // clock
  input wire logic clk,
  // pin from the block
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // seen level and measurements
  output logic level,
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [15:0] rises
);
  logic prev_q = 1'b0; // level one clock ago
  logic [15:0] cnt_q = 16'h0000; // clocks since last rise
  logic [15:0] rise_q = 16'h0000; // rising edges seen
  logic held_q = 1'b0; // last level the block drove
  // a released pin settles to the inverse of its last driven level
  assign level = pin_oe_n ? ~held_q : pin_out;
  assign rises = rise_q;
  // edge timing of the pin
  always_ff @(posedge clk) begin
    if (!pin_oe_n) held_q <= pin_out;
    prev_q <= level;
    if (level && !prev_q) begin
      per_len <= cnt_q;
      rise_q <= rise_q + 16'h0001;
      cnt_q <= 16'h0001;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      // falling edge closes the high time
      if (!level && prev_q) hi_len <= cnt_q;
    end
  end
endmodule : pwg_load_model
`default_nettype wire

// file: pwg_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// port checks for the pwm block
module pwg_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pulse pin
  input wire logic pulse_pin_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_wr_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_rd_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  a_rd_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data repeated");
  a_rd_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
  a_pin_reset: assert property (
    $rose(rst_b) |-> !pulse_pin_out [*3]) else $error("pin high after reset");
  a_pin_period: assert property (
    $rose(pulse_pin_out) |=> !$rose(pulse_pin_out) [*3]) else $error("period too short");
  // main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pulse: cover property ($rose(pulse_pin_out) ##[1:300] $fell(pulse_pin_out));
endmodule : pwg_top_sva
bind pwg_top pwg_top_sva u_sva (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .pulse_pin_out(pulse_pin_out));
`default_nettype wire

// file: ten_bit_pwm_generator_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "pwg_regs.svh"
// register-driven checks of the pwm block
module ten_bit_pwm_generator_test;
  import pwg_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic [3:0] ws = 4'hF;
  wire logic awr, wr, bv, arr, rv, pin, oe_n, lvl;
  wire logic [31:0] rd;
  wire logic [15:0] hi, per, nr;
  pwg_resp_t br, rr;
  int fails = 0, num_checks = 0;
  pwg_top DUT (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr), .pulse_pin_out(pin),
    .pulse_pin_oe_n(oe_n));
  pwg_load_model LOAD (.clk(clk), .pin_out(pin), .pin_oe_n(oe_n), .level(lvl),
    .hi_len(hi), .per_len(per), .rises(nr));
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic bad(input string m);
    fails++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : bad
  task automatic hang;
    bad("wait ran out");
    finish_test();
  endtask : hang
  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) bad($sformatf("value %0h not %0h", g, e));
  endtask : chk_v
  task automatic chk_r(input pwg_resp_t g, input pwg_resp_t e);
    num_checks++;
    if (g !== e) bad("response code");
  endtask : chk_r
  // one write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output pwg_resp_t r);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h000000, d};
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv && n < 200);
    if (!bv) hang();
    r = br;
    bry <= 1'b0;
  endtask : axi_wr
  // one read
  task automatic axi_rd(input logic [7:0] a, output logic [15:0] d, output pwg_resp_t r);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 200);
    if (!rv) hang();
    d = rd[15:0];
    r = rr;
    rry <= 1'b0;
  endtask : axi_rd
  task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
    pwg_resp_t r;
    axi_wr(a, d, r);
    chk_r(r, PWG_RESP_OKAY);
  endtask : wr_ok
  task automatic rd_is(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    pwg_resp_t r;
    axi_rd(a, d, r);
    chk_v(d, e);
    chk_r(r, PWG_RESP_OKAY);
  endtask : rd_is
  // wait for k rising edges of the pin
  task automatic wait_rises(input int k);
    logic [15:0] s;
    int n;
    repeat (k) begin
      s = nr;
      n = 0;
      while (nr === s && n < 3000) begin
        @(posedge clk);
        n++;
      end
      if (nr === s) hang();
    end
  endtask : wait_rises
  // reset values, read-only timer, unmapped place
  task automatic t_reset;
    logic [15:0] d;
    pwg_resp_t r;
    chk_v({14'h0000, pin, oe_n}, 16'h0001);
    rd_is(`PWG_CTRL_OFS, 16'h0000);
    rd_is(`PWG_PERIOD_OFS, 16'h00FF);
    rd_is(`PWG_DUTY_WR_OFS, 16'h0000);
    rd_is(`PWG_DUTY_SH_OFS, 16'h0000);
    wr_ok(`PWG_TIMER_OFS, 8'h77);
    rd_is(`PWG_TIMER_OFS, 16'h0000);
    rd_is(`PWG_TCTRL_OFS, 16'h0000);
    rd_is(`PWG_DIR_OFS, 16'h0001);
    axi_rd(8'h1C, d, r);
    chk_r(r, PWG_RESP_SLVERR);
    axi_wr(8'h1C, 8'h5A, r);
    chk_r(r, PWG_RESP_SLVERR);
  endtask : t_reset
  // duty 9, limit 3, every prescale code
  task automatic t_prescale;
    int f [4] = '{1, 4, 16, 16};
    logic [15:0] d;
    pwg_resp_t r;
    wr_ok(`PWG_DIR_OFS, 8'h00);
    wr_ok(`PWG_PERIOD_OFS, 8'h03);
    wr_ok(`PWG_DUTY_WR_OFS, 8'h02);
    wr_ok(`PWG_CTRL_OFS, 8'h1C);
    for (int p = 0; p < 4; p++) begin
      wr_ok(`PWG_TCTRL_OFS, 8'h04 | 8'(p));
      wait_rises(3);
      chk_v(per, 16'(16 * f[p]));
      chk_v(hi, 16'(9 * f[p]));
    end
    chk_v({15'h0000, oe_n}, 16'h0000);
    axi_rd(`PWG_TIMER_OFS, d, r);
    chk_v({15'h0000, d <= 16'h0003}, 16'h0001);
    rd_is(`PWG_DUTY_SH_OFS, 16'h0002);
    wr_ok(`PWG_DUTY_SH_OFS, 8'h55);
    rd_is(`PWG_DUTY_SH_OFS, 16'h0002);
  endtask : t_prescale
  // change duty inside a high time
  task automatic t_duty_hold;
    wr_ok(`PWG_TCTRL_OFS, 8'h04);
    wait_rises(2);
    wr_ok(`PWG_CTRL_OFS, 8'h3C);
    wr_ok(`PWG_DUTY_WR_OFS, 8'h01);
    wait_rises(1);
    chk_v(hi, 16'h0009);
    wait_rises(2);
    chk_v(hi, 16'h0007);
  endtask : t_duty_hold
  // zero duty never sets the pin
  task automatic t_zero;
    logic [15:0] s;
    wr_ok(`PWG_DUTY_WR_OFS, 8'h00);
    wr_ok(`PWG_CTRL_OFS, 8'h0C);
    repeat (40) @(posedge clk);
    s = nr;
    repeat (40) @(posedge clk);
    chk_v(nr, s);
    chk_v({15'h0000, pin}, 16'h0000);
  endtask : t_zero
  // clearing control mid-pulse drops the pin
  task automatic t_clear;
    logic [15:0] s;
    wr_ok(`PWG_DUTY_WR_OFS, 8'h03);
    wait_rises(2);
    wr_ok(`PWG_CTRL_OFS, 8'h00);
    repeat (2) @(posedge clk);
    chk_v({15'h0000, pin}, 16'h0000);
    s = nr;
    repeat (40) @(posedge clk);
    chk_v(nr, s);
  endtask : t_clear
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_prescale();
    t_duty_hold();
    t_zero();
    t_clear();
    finish_test();
  end
endmodule : ten_bit_pwm_generator_test
`default_nettype wire
